//--- threshold_regs_pkg.sv
// constants for the input-threshold and phase_offset_config command registers
// assumes command codes and word data come from a word-level management engine
package threshold_regs_pkg;
    // ==========================================================
    // command codes
    localparam logic [7:0]  CMD_RESTORE_ALL  = 8'h16;
    localparam logic [7:0]  CMD_TURN_ON      = 8'h35;
    localparam logic [7:0]  CMD_TURN_OFF     = 8'h36;
    localparam logic [7:0]  CMD_PHASE_OFFSET_CONFIG   = 8'h37;
    localparam logic [7:0]  CMD_STATUS_INPUT = 8'h7c;
    // ==========================================================
    // linear word layout
    localparam int          EXP_MSB          = 15;
    localparam int          EXP_LSB          = 11;
    localparam int          MAN_MSB          = 10;
    localparam logic [4:0]  THRESH_EXP_RST   = 5'h1e;
    // thresholds in 0.25 V steps: 2.50 V, 2.25 V, 18.25 V
    localparam logic [10:0] ON_MIN_Q         = 11'h00a;
    localparam logic [10:0] OFF_MIN_Q        = 11'h009;
    localparam logic [10:0] THRESH_MAX_Q     = 11'h049;
    localparam logic [10:0] ON_MAN_RST       = 11'h00a;
    localparam logic [10:0] OFF_MAN_RST      = 11'h009;
    // ==========================================================
    // phase_offset_config word layout
    localparam int          GROUP_MSB        = 11;
    localparam int          GROUP_LSB        = 8;
    localparam int          NUM_MSB          = 7;
    localparam int          NUM_LSB          = 4;
    localparam int          ORDER_MSB        = 3;
    localparam logic [3:0]  NUM_MIN          = 4'h1;
    localparam logic [3:0]  NUM_MAX          = 4'h4;
    localparam logic [15:0] PHASE_OFFSET_CONFIG_RST   = 16'h0010;
    // ==========================================================
    // input status bits
    localparam int          ST_LOW_OFF_BIT   = 3;
    localparam int          ST_LOW_FAULT_BIT = 4;
endpackage : threshold_regs_pkg

//--- input_threshold_phase_offset_config_regs.sv
// input turn-on/off thresholds, low-input status and phase_offset_config phase word
// assumes a word-level command engine on clk; vin, enable and sync come from outside
`timescale 1ns/100ps

module input_threshold_phase_offset_config_regs
    import threshold_regs_pkg::*;
(
    input  wire logic        clk,            // 10 MHz
    input  wire logic        rstn,           // async, active low
    input  wire logic        ce,             // clock enable
    input  wire logic [7:0]  cmd_code,       // command code
    input  wire logic        wr_stb,         // word write strobe
    input  wire logic [15:0] wr_data,        // write word
    input  wire logic        rd_stb,         // word read strobe
    output logic      [15:0] rd_data_q,      // read word
    output logic             rd_valid_q,     // read answer pulse
    output logic             unsupported_q,  // rejected write pulse
    output logic             restore_req_q,  // restore-all request pulse
    input  wire logic        nvm_load,       // restored words valid
    input  wire logic [15:0] nvm_on_word,    // restored turn-on word
    input  wire logic [15:0] nvm_off_word,   // restored turn-off word
    input  wire logic [15:0] nvm_il_word,    // restored phase_offset_config word
    input  wire logic        stack_multi,    // stack setting, multi-phase
    input  wire logic [10:0] power_stage_input_voltage, // sensed, 0.25 V units
    input  wire logic        enable_req,     // conversion enable conditions met
    input  wire logic        sync_in,        // shared sync pin
    output logic             conv_on_q,      // conversion permitted
    output logic             low_input_fault_q, // low-input fault
    output logic             low_off_q,      // off due to low input
    output logic             mod_sync_q      // phase-shifted modulator pulse
);
    // ==========================================================
    // helpers
    function automatic logic [31:0] to_quarters(input logic [15:0] w);
        logic signed [4:0]  e;
        logic        [10:0] m;
        e = signed'(w[EXP_MSB:EXP_LSB]);
        m = w[MAN_MSB:0];
        if (m[10])
            to_quarters = 32'hffff_ffff;
        else if (e >= -5'sd2)
            to_quarters = {21'h0, m} << (e + 5'sd2);
        else
            to_quarters = {21'h0, m} >> (-(e + 5'sd2));
    endfunction : to_quarters
    function automatic logic in_range(input logic [31:0] q, input logic [10:0] lo);
        in_range = (q >= {21'h0, lo}) && (q <= {21'h0, THRESH_MAX_Q});
    endfunction : in_range
    function automatic logic [10:0] clamp_q(input logic [31:0] q, input logic [10:0] lo);
        if (q < {21'h0, lo})
            clamp_q = lo;
        else if (q > {21'h0, THRESH_MAX_Q})
            clamp_q = THRESH_MAX_Q;
        else
            clamp_q = q[10:0];
    endfunction : clamp_q
    function automatic logic il_legal(input logic [15:0] w);
        il_legal = (w[NUM_MSB:NUM_LSB] >= NUM_MIN) && (w[NUM_MSB:NUM_LSB] <= NUM_MAX)
                   && (w[ORDER_MSB:0] < w[NUM_MSB:NUM_LSB]);
    endfunction : il_legal

    // ==========================================================
    // input synchronisers
    logic [10:0] vin_s1_q, vin_s2_q, vin_s3_q, vin_q;
    logic        en_s1_q, en_q, sync_s1_q, sync_q, sync_prev_q;

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            vin_s1_q    <= '0;
            vin_s2_q    <= '0;
            vin_s3_q    <= '0;
            vin_q       <= '0;
            en_s1_q     <= 1'b0;
            en_q        <= 1'b0;
            sync_s1_q   <= 1'b0;
            sync_q      <= 1'b0;
            sync_prev_q <= 1'b0;
        end else if (ce) begin
            vin_s1_q    <= power_stage_input_voltage;
            vin_s2_q    <= vin_s1_q;
            vin_s3_q    <= vin_s2_q;
            if (vin_s2_q == vin_s3_q)                                      // word only once settled
                vin_q   <= vin_s2_q;
            en_s1_q     <= enable_req;
            en_q        <= en_s1_q;
            sync_s1_q   <= sync_in;
            sync_q      <= sync_s1_q;
            sync_prev_q <= sync_q;
        end
    end

    // ==========================================================
    // command registers
    logic [10:0] on_threshold_mantissa_q, on_threshold_mantissa_d;
    logic [10:0] off_threshold_mantissa_q, off_threshold_mantissa_d;
    logic [15:0] il_q, il_d;
    logic        il_locked_q, il_locked_d, stack_seen_q, stack_seen_d;
    logic [15:0] rd_data_d;
    logic        rd_valid_d, unsupported_d, restore_req_d;
    logic [31:0] wr_quarters;

    always_comb begin
        on_threshold_mantissa_d  = on_threshold_mantissa_q;
        off_threshold_mantissa_d = off_threshold_mantissa_q;
        il_d          = il_q;
        il_locked_d   = il_locked_q;
        stack_seen_d  = 1'b1;
        rd_data_d     = rd_data_q;
        rd_valid_d    = 1'b0;
        unsupported_d = 1'b0;
        restore_req_d = 1'b0;
        wr_quarters   = to_quarters(wr_data);
        if (!stack_seen_q)
            il_locked_d = stack_multi;
        if (nvm_load) begin
            on_threshold_mantissa_d  = clamp_q(to_quarters(nvm_on_word), ON_MIN_Q);
            off_threshold_mantissa_d = clamp_q(to_quarters(nvm_off_word), OFF_MIN_Q);
            if (il_legal(nvm_il_word))
                il_d = {4'h0, nvm_il_word[GROUP_MSB:0]};
        end else if (wr_stb) begin
            case (cmd_code)
                CMD_TURN_ON: begin
                    if (in_range(wr_quarters, ON_MIN_Q))
                        on_threshold_mantissa_d = wr_quarters[10:0];
                    else
                        unsupported_d = 1'b1;
                end
                CMD_TURN_OFF: begin
                    if (in_range(wr_quarters, OFF_MIN_Q))
                        off_threshold_mantissa_d = wr_quarters[10:0];
                    else
                        unsupported_d = 1'b1;
                end
                CMD_PHASE_OFFSET_CONFIG: begin
                    if (!il_locked_q && il_legal(wr_data))
                        il_d = {4'h0, wr_data[GROUP_MSB:0]};
                    else
                        unsupported_d = 1'b1;
                end
                CMD_RESTORE_ALL: restore_req_d = 1'b1;
                default: unsupported_d = 1'b1;
            endcase
        end
        if (rd_stb) begin
            rd_valid_d = 1'b1;
            case (cmd_code)
                CMD_TURN_ON:      rd_data_d = {THRESH_EXP_RST, on_threshold_mantissa_q};
                CMD_TURN_OFF:     rd_data_d = {THRESH_EXP_RST, off_threshold_mantissa_q};
                CMD_PHASE_OFFSET_CONFIG:   rd_data_d = il_q;
                CMD_STATUS_INPUT: begin
                    rd_data_d = 16'h0000;
                    rd_data_d[ST_LOW_OFF_BIT]   = low_off_q;
                    rd_data_d[ST_LOW_FAULT_BIT] = low_input_fault_q;
                end
                default:          rd_data_d = 16'h0000;
            endcase
        end
    end

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            on_threshold_mantissa_q  <= ON_MAN_RST;
            off_threshold_mantissa_q <= OFF_MAN_RST;
            il_q          <= PHASE_OFFSET_CONFIG_RST;
            il_locked_q   <= 1'b0;
            stack_seen_q  <= 1'b0;
            rd_data_q     <= '0;
            rd_valid_q    <= 1'b0;
            unsupported_q <= 1'b0;
            restore_req_q <= 1'b0;
        end else if (ce) begin
            on_threshold_mantissa_q  <= on_threshold_mantissa_d;
            off_threshold_mantissa_q <= off_threshold_mantissa_d;
            il_q          <= il_d;
            il_locked_q   <= il_locked_d;
            stack_seen_q  <= stack_seen_d;
            rd_data_q     <= rd_data_d;
            rd_valid_q    <= rd_valid_d;
            unsupported_q <= unsupported_d;
            restore_req_q <= restore_req_d;
        end
    end

    // ==========================================================
    // conversion permit and low-input status
    logic conv_on_d, armed_q, armed_d, low_fault_d, low_off_d;
    logic above_on, below_off;

    always_comb begin
        above_on    = vin_q > on_threshold_mantissa_q;
        below_off   = vin_q < off_threshold_mantissa_q;
        conv_on_d   = conv_on_q;
        if (above_on)
            conv_on_d = 1'b1;
        else if (below_off)
            conv_on_d = 1'b0;
        armed_d     = armed_q | above_on;
        low_fault_d = armed_q & below_off;
        low_off_d   = en_q & below_off;
    end

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            conv_on_q         <= 1'b0;
            armed_q           <= 1'b0;
            low_input_fault_q <= 1'b0;
            low_off_q         <= 1'b0;
        end else if (ce) begin
            conv_on_q         <= conv_on_d;
            armed_q           <= armed_d;
            low_input_fault_q <= low_fault_d;
            low_off_q         <= low_off_d;
        end
    end

    // ==========================================================
    // phase delay: fire when acc (step = size) reaches period * order
    logic [7:0]  per_cnt_q, per_cnt_d, period_q, period_d;
    logic [11:0] acc_q, acc_d, target;
    logic        fired_q, fired_d, mod_sync_d, sync_rise;

    always_comb begin
        sync_rise  = sync_q & ~sync_prev_q;
        target     = {4'h0, period_q} * {8'h00, il_q[ORDER_MSB:0]};
        per_cnt_d  = (per_cnt_q == 8'hff) ? per_cnt_q : per_cnt_q + 8'h01;
        period_d   = period_q;
        acc_d      = (acc_q > 12'hff0) ? acc_q : acc_q + {8'h00, il_q[NUM_MSB:NUM_LSB]};
        fired_d    = fired_q;
        mod_sync_d = 1'b0;
        if (sync_rise) begin
            period_d  = per_cnt_q;
            per_cnt_d = 8'h01;
            acc_d     = {8'h00, il_q[NUM_MSB:NUM_LSB]};                    // first step counts now
            fired_d   = 1'b0;
            if (il_q[ORDER_MSB:0] == 4'h0) begin
                mod_sync_d = 1'b1;
                fired_d    = 1'b1;
            end
        end else if (!fired_q && acc_q >= target) begin
            mod_sync_d = 1'b1;
            fired_d    = 1'b1;
        end
    end

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            per_cnt_q  <= '0;
            period_q   <= '0;
            acc_q      <= '0;
            fired_q    <= 1'b1;
            mod_sync_q <= 1'b0;
        end else if (ce) begin
            per_cnt_q  <= per_cnt_d;
            period_q   <= period_d;
            acc_q      <= acc_d;
            fired_q    <= fired_d;
            mod_sync_q <= mod_sync_d;
        end
    end

    // ==========================================================
    // checks
    property p_on_range;
        @(posedge clk) disable iff (!rstn)
        (on_threshold_mantissa_q >= ON_MIN_Q) && (on_threshold_mantissa_q <= THRESH_MAX_Q);
    endproperty
    a_on_range: assert property (p_on_range) else $error("turn-on out of range");
    property p_off_range;
        @(posedge clk) disable iff (!rstn)
        (off_threshold_mantissa_q >= OFF_MIN_Q) && (off_threshold_mantissa_q <= THRESH_MAX_Q);
    endproperty
    a_off_range: assert property (p_off_range) else $error("turn-off out of range");
    property p_reject;
        @(posedge clk) disable iff (!rstn)
        ce && wr_stb && !nvm_load && cmd_code == CMD_TURN_ON
            && !in_range(to_quarters(wr_data), ON_MIN_Q)
        |=> unsupported_q && $stable(on_threshold_mantissa_q);
    endproperty
    a_reject: assert property (p_reject) else $error("bad turn-on accepted");
    property p_top_zero;
        @(posedge clk) disable iff (!rstn) il_q[15:12] == 4'h0;
    endproperty
    a_top_zero: assert property (p_top_zero) else $error("phase_offset_config top bits set");
    property p_il_legal;
        @(posedge clk) disable iff (!rstn) il_legal(il_q);
    endproperty
    a_il_legal: assert property (p_il_legal) else $error("illegal phase_offset_config");
    property p_locked;
        @(posedge clk) disable iff (!rstn)
        il_locked_q && !nvm_load |=> $stable(il_q);
    endproperty
    a_locked: assert property (p_locked) else $error("locked phase_offset_config changed");
    property p_lock_fixed;
        @(posedge clk) disable iff (!rstn) stack_seen_q |=> $stable(il_locked_q);
    endproperty
    a_lock_fixed: assert property (p_lock_fixed) else $error("lock re-evaluated");
    property p_mask;
        @(posedge clk) disable iff (!rstn) !armed_q |=> !low_input_fault_q;
    endproperty
    a_mask: assert property (p_mask) else $error("fault before first turn-on");
    property p_permit;
        @(posedge clk) disable iff (!rstn)
        ce && vin_q > on_threshold_mantissa_q |=> conv_on_q;
    endproperty
    a_permit: assert property (p_permit) else $error("no turn-on above threshold");
    property p_low_off;
        @(posedge clk) disable iff (!rstn)
        ce && en_q && vin_q < off_threshold_mantissa_q
        |=> low_off_q && conv_on_q == $past(vin_q > on_threshold_mantissa_q);
    endproperty
    a_low_off: assert property (p_low_off) else $error("low input not reported");
    property p_read_on;
        @(posedge clk) disable iff (!rstn)
        ce && rd_stb && cmd_code == CMD_TURN_ON
        |=> rd_valid_q && rd_data_q[EXP_MSB:EXP_LSB] == THRESH_EXP_RST;
    endproperty
    a_read_on: assert property (p_read_on) else $error("turn-on exponent wrong");
endmodule : input_threshold_phase_offset_config_regs

//--- pmbus_host_model.sv
// word-level management host: issues single word writes and reads
// assumes the device takes strobes on rising clk and answers one edge later
`timescale 1ns/100ps
module pmbus_host_model (
    input  wire logic        clk,           // system clock
    output logic      [7:0]  cmd_code,      // command code
    output logic             wr_stb,        // write strobe
    output logic      [15:0] wr_data,       // write word
    output logic             rd_stb,        // read strobe
    input  wire logic [15:0] rd_data_q,     // read answer
    input  wire logic        rd_valid_q,    // read answer pulse
    input  wire logic        unsupported_q  // rejected write pulse
);
    initial begin
        cmd_code = 8'h00;
        wr_stb   = 1'b0;
        wr_data  = 16'h0000;
        rd_stb   = 1'b0;
    end
    // ==========================================================
    // idle gap of 0..2 cycles, so both prompt and slow hosts show up
    task automatic idle;
        repeat ($urandom_range(0, 2)) @(negedge clk);
    endtask : idle
    task automatic wr(input logic [7:0] code, input logic [15:0] data, output logic refused);
        idle();
        @(negedge clk);
        cmd_code = code;
        wr_data  = data;
        wr_stb   = 1'b1;
        @(negedge clk);
        wr_stb   = 1'b0;
        wr_data  = ~data;
        refused  = unsupported_q;
    endtask : wr
    task automatic rd(input logic [7:0] code, output logic [15:0] data, output logic ok);
        idle();
        @(negedge clk);
        cmd_code = code;
        rd_stb   = 1'b1;
        @(negedge clk);
        rd_stb   = 1'b0;
        ok       = rd_valid_q;
        data     = rd_data_q;
    endtask : rd
endmodule : pmbus_host_model

//--- tb_input_threshold_phase_offset_config_regs.sv
// self-checking bench for the threshold and phase_offset_config command registers
// assumes the host model drives the command port; sync runs free at 800 ns
`timescale 1ns/100ps
module tb_input_threshold_phase_offset_config_regs;
    import threshold_regs_pkg::*;
    logic        clk = 1'b0, rstn = 1'b0, ce = 1'b1, nvm_load = 1'b0;
    logic [15:0] nvm_on_word = 16'h0000, nvm_off_word = 16'h0000, nvm_il_word = 16'h0000;
    logic        stack_multi = 1'b0, enable_req = 1'b0, sync_in = 1'b0;
    logic [10:0] power_stage_input_voltage = 11'h000;
    wire logic [7:0]  cmd_code;
    wire logic [15:0] wr_data, rd_data_q;
    wire logic        wr_stb, rd_stb, rd_valid_q, unsupported_q, restore_req_q;
    wire logic        conv_on_q, low_input_fault_q, low_off_q, mod_sync_q;
    int          err_total = 0, num_checks = 0, cyc = 0, rise_cyc = 0, ph = 0, ph0 = 0;
    int          pulses = 0, i, n, o;
    logic [15:0] rv, w;
    logic [11:0] e;
    logic        bad, ok, sel;
    logic [10:0] shadow [2];
    logic [10:0] corner [8] = '{11'd9, 11'd10, 11'd73, 11'd74, 11'd8, 11'd9, 11'd73, 11'd74};

    always #50 clk = ~clk;
    initial begin
        #37;
        forever #400 sync_in = ~sync_in;
    end
    always @(posedge sync_in) rise_cyc = cyc;
    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (mod_sync_q) begin
            ph     <= (cyc - rise_cyc) % 8;
            pulses <= pulses + 1;
        end
        if (cyc >= 20000) begin
            err_total++;
            results();
        end
    end

    input_threshold_phase_offset_config_regs dut_u (.clk(clk), .rstn(rstn), .ce(ce),
        .cmd_code(cmd_code), .wr_stb(wr_stb), .wr_data(wr_data), .rd_stb(rd_stb),
        .rd_data_q(rd_data_q), .rd_valid_q(rd_valid_q), .unsupported_q(unsupported_q),
        .restore_req_q(restore_req_q), .nvm_load(nvm_load), .nvm_on_word(nvm_on_word),
        .nvm_off_word(nvm_off_word), .nvm_il_word(nvm_il_word), .stack_multi(stack_multi),
        .power_stage_input_voltage(power_stage_input_voltage), .enable_req(enable_req),
        .sync_in(sync_in), .conv_on_q(conv_on_q), .low_input_fault_q(low_input_fault_q),
        .low_off_q(low_off_q), .mod_sync_q(mod_sync_q));
    pmbus_host_model host_u (.clk(clk), .cmd_code(cmd_code), .wr_stb(wr_stb),
        .wr_data(wr_data), .rd_stb(rd_stb), .rd_data_q(rd_data_q),
        .rd_valid_q(rd_valid_q), .unsupported_q(unsupported_q));

    // ==========================================================
    // checking helpers
    task automatic results;
        if (err_total == 0 && num_checks > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask : results
    task automatic chk(input logic [15:0] got, input logic [15:0] exp, input string what);
        num_checks++;
        if (got !== exp) begin
            err_total++;
            $display("Error at %0t: %s got %h expected %h", $time, what, got, exp);
        end
    endtask : chk
    task automatic rdchk(input logic [7:0] code, input logic [15:0] exp);
        host_u.rd(code, rv, ok);
        chk({15'h0, ok}, 16'h0001, "read answer");
        chk(rv, exp, "read word");
    endtask : rdchk
    task automatic wrchk(input logic [7:0] code, input logic [15:0] data, input logic refuse);
        host_u.wr(code, data, bad);
        chk({15'h0, bad}, {15'h0, refuse}, "write refusal");
    endtask : wrchk
    // {accept, quarter-volt count}; exponent -3 halves the mantissa, rounding down
    function automatic logic [11:0] thr_exp(input logic on, input logic [15:0] wd);
        logic [10:0] q;
        logic [10:0] lo;
        q  = (wd[15:11] == 5'h1d) ? {1'b0, wd[10:1]} : wd[10:0];
        lo = on ? ON_MIN_Q : OFF_MIN_Q;
        return {(q >= lo && q <= THRESH_MAX_Q && !wd[10]), q};
    endfunction : thr_exp
    task automatic do_reset(input logic multi);
        @(negedge clk);
        rstn        = 1'b0;
        stack_multi = multi;
        repeat (6) @(negedge clk);
        rstn = 1'b1;
        repeat (3) @(negedge clk);
    endtask : do_reset
    task automatic do_restore(input logic [15:0] on_w, off_w, il_w);
        host_u.wr(CMD_RESTORE_ALL, 16'h0000, bad);
        chk({15'h0, restore_req_q}, 16'h0001, "restore request");
        nvm_on_word  = on_w;
        nvm_off_word = off_w;
        nvm_il_word  = il_w;
        nvm_load     = 1'b1;
        @(negedge clk);
        nvm_load = 1'b0;
        @(negedge clk);
    endtask : do_restore
    task automatic step(input int v, input logic en, input logic [2:0] ex);
        @(negedge clk);
        power_stage_input_voltage = 11'(v);
        enable_req = en;
        repeat (6) @(negedge clk);
        chk({13'h0, conv_on_q, low_input_fault_q, low_off_q}, {13'h0, ex}, "power state");
    endtask : step

    // ==========================================================
    // main sequence
    initial begin
        rv = 16'($urandom(32'h60cb));
        do_reset(1'b0);
        rdchk(CMD_TURN_ON, 16'hf00a);
        rdchk(CMD_TURN_OFF, 16'hf009);
        rdchk(CMD_PHASE_OFFSET_CONFIG, 16'h0010);
        do_restore(16'he853, 16'hf014, 16'h0321);
        rdchk(CMD_TURN_ON, 16'hf029);
        rdchk(CMD_TURN_OFF, 16'hf014);
        rdchk(CMD_PHASE_OFFSET_CONFIG, 16'h0321);
        shadow[1] = 11'd41;
        shadow[0] = 11'd20;
        for (i = 0; i < 32; i++) begin
            sel = (i < 8) ? (i < 4) : 1'($urandom_range(0, 1));
            if (i < 8) w = {5'h1e, corner[i]};
            else if ($urandom_range(0, 1)) w = {5'h1e, 11'($urandom_range(0, 80))};
            else w = {5'h1d, 11'($urandom_range(20, 147))};
            e = thr_exp(sel, w);
            wrchk(sel ? CMD_TURN_ON : CMD_TURN_OFF, w, !e[11]);
            if (e[11]) shadow[sel] = e[10:0];
            rdchk(sel ? CMD_TURN_ON : CMD_TURN_OFF, {THRESH_EXP_RST, shadow[sel]});
        end
        @(negedge clk);
        ce = 1'b0;
        host_u.wr(CMD_TURN_ON, 16'hf020, bad);
        ce = 1'b1;
        rdchk(CMD_TURN_ON, {THRESH_EXP_RST, shadow[1]});
        wrchk(8'h38, 16'h0000, 1'b1);
        rdchk(8'h38, 16'h0000);
        for (n = 1; n <= 4; n++) for (o = 0; o < n; o++) begin
            w = {4'h0, 4'($urandom_range(0, 15)), 4'(n), 4'(o)};
            wrchk(CMD_PHASE_OFFSET_CONFIG, w, 1'b0);
            rdchk(CMD_PHASE_OFFSET_CONFIG, w);
        end
        wrchk(CMD_PHASE_OFFSET_CONFIG, 16'h0500, 1'b1);
        wrchk(CMD_PHASE_OFFSET_CONFIG, 16'h0650, 1'b1);
        wrchk(CMD_PHASE_OFFSET_CONFIG, 16'h0733, 1'b1);
        rdchk(CMD_PHASE_OFFSET_CONFIG, w);
        for (o = 0; o < 3; o++) begin
            wrchk(CMD_PHASE_OFFSET_CONFIG, {8'h00, 4'h4, 4'(o)}, 1'b0);
            repeat (24) @(negedge clk);
            pulses = 0;
            repeat (32) @(negedge clk);
            chk(16'(pulses), 16'd4, "sync pulses");
            if (o == 0) ph0 = ph;
            chk(16'((ph - ph0 + 8) % 8), 16'(2 * o), "phase offset");
        end
        do_restore(16'hf028, 16'hf01e, 16'h0010);
        step(35, 1'b0, 3'b000);
        step(20, 1'b1, 3'b001);
        step(45, 1'b1, 3'b100);
        step(35, 1'b1, 3'b100);
        step(20, 1'b1, 3'b011);
        rdchk(CMD_STATUS_INPUT, 16'h0018);
        step(20, 1'b0, 3'b010);
        do_restore(16'hf028, 16'hf01e, 16'h0010);
        step(20, 1'b0, 3'b010);
        @(negedge clk);
        stack_multi = 1'b1;
        wrchk(CMD_PHASE_OFFSET_CONFIG, 16'h0321, 1'b0);
        do_reset(1'b1);
        wrchk(CMD_PHASE_OFFSET_CONFIG, 16'h0321, 1'b1);
        rdchk(CMD_PHASE_OFFSET_CONFIG, 16'h0010);
        results();
    end
endmodule : tb_input_threshold_phase_offset_config_regs
